// ==== dpa_align_ctrl.sv ====
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - A set enable bit turns its channel's aligner on.
// - Enables unused means every channel is on.
// - Aligner watches data, switches phase when needed.
// - Freeze input keeps the present phase.
// - FIFO sits between aligner and alignment logic.
// - FIFO reset bit holds that FIFO cleared.
// - FIFO reset exists only outside forwarded-clock mode.
// - Aligner reset clears it; user must retrain.
// - Auto option holds FIFO until first lock.
// - Eight sampling phases, 45 degrees apart.
// - Each channel reports lock.
// - Lock rises only after initial acquisition.
// - Sticky lock stays until a reset.
// - Non-sticky lock drops on a chosen condition.
// - No lock in fixed-phase or forwarded mode.
// - First condition: drop on any switch.
// - Second condition: two same-way switches drop.
// - Lock reset clears only lock detection.
// - Forwarded mode divides clock, bypasses FIFO.
module dpa_align_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [dpa_pkg::NCH-1:0] pd_obs,
	input wire logic [dpa_pkg::NCH-1:0] pd_early,
	input wire logic [dpa_pkg::NCH-1:0] pd_late,
	input wire logic [dpa_pkg::NCH-1:0][dpa_pkg::DW-1:0] deser_data,
	input wire logic [dpa_pkg::NCH-1:0] deser_valid,
	output logic [dpa_pkg::NCH-1:0][dpa_pkg::DW-1:0] align_data,
	output logic [dpa_pkg::NCH-1:0] align_valid,
	output logic [dpa_pkg::NCH-1:0] dpa_locked,
	output logic [dpa_pkg::NCH-1:0][dpa_pkg::PH_W-1:0] phase_sel,
	output logic fwd_div_clk
);
	import dpa_pkg::*;
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	// All block state outside the per-channel tracker and lock detector lives in one record so that reset and update are uniform.
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl; // Mode bits.
		logic [CHAN_W-1:0] chan; // Per-channel enable, freeze and reset bits.
		logic awready; // Write address accepted when high.
		logic wready; // Write data accepted when high.
		logic bvalid; // Write answer pending.
		logic [1:0] bresp; // Write answer code.
		logic aw_got; // Write address held.
		logic w_got; // Write data held.
		logic [31:0] awaddr; // Held write address.
		logic [31:0] wdata; // Held write data.
		logic [3:0] wstrb; // Held byte strobes.
		logic arready; // Read address accepted when high.
		logic rvalid; // Read answer pending.
		logic [1:0] rresp; // Read answer code.
		logic [31:0] rdata; // Read answer data.
		logic [NCH-1:0] lock; // Lock outputs.
		logic [NCH-1:0] first_lock; // Lock has been seen since the aligner reset.
		logic [NCH-1:0] fheld; // FIFO held in reset.
		logic [NCH-1:0][FDEPTH-1:0][DW-1:0] mem; // FIFO storage.
		logic [NCH-1:0][FP_W-1:0] wp; // FIFO write pointers.
		logic [NCH-1:0][FP_W-1:0] rp; // FIFO read pointers.
		logic [NCH-1:0][FP_W:0] cnt; // FIFO occupancy.
		logic [NCH-1:0][DW-1:0] odata; // Words toward the alignment logic.
		logic [NCH-1:0] ovalid; // Word valid toward the alignment logic.
		logic [DIV_W-1:0] div; // Forwarded clock divider count.
		logic divclk; // Divided forwarded clock.
	} dpa_state_t;
	localparam dpa_state_t ST_RST = '{ctrl: CTRL_RST, default: '0}; // Reset image.
	dpa_state_t st_reg, st_next; // Registered state and its next value.
	dpa_reg_t wsel; // Register chosen by the pending write.
	dpa_reg_t rsel; // Register chosen by the read request.
	logic [31:0] wmerged; // Write data merged under byte strobes.
	logic [NCH-1:0] en_eff; // Effective aligner enable.
	logic [NCH-1:0] hold; // Freeze request.
	logic [NCH-1:0] drst; // Aligner reset.
	logic [NCH-1:0] lrst; // Lock detector reset.
	logic [NCH-1:0] frst; // Effective FIFO reset.
	logic [NCH-1:0] lk_raw; // Detector lock before mode gating.
	logic [NCH-1:0] step; // Phase switch pulses.
	logic [NCH-1:0] step_up; // Direction of each switch.
	logic lock_mode; // Lock reporting allowed in this mode.
	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	// Picks the register at an address; misaligned or high addresses map to none.
	function automatic dpa_reg_t reg_sel(input logic [31:0] addr);
		dpa_reg_t s;
		s = RS_NONE;
		if (addr[31:4] == 28'h0000000) begin
			case (addr[3:0])
				OFF_CTRL: s = RS_CTRL;
				OFF_CHAN: s = RS_CHAN;
				OFF_STAT: s = RS_STAT;
				OFF_PHASE: s = RS_PHASE;
				default: s = RS_NONE;
			endcase
		end
		return s;
	endfunction
	// Reads one channel's bit out of a channel field.
	function automatic logic chan_bit(input logic [CHAN_W-1:0] chan, input int base, input int ch);
		return chan[base + ch];
	endfunction
	// Merges new write data into an old word under byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				m[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return m;
	endfunction
	// ------------------------------------------------------------
	// Per-channel aligners
	// ------------------------------------------------------------
	// Lock is meaningless when the phase is fixed or the clock is forwarded.
	assign lock_mode = !st_reg.ctrl[C_FIXED] && !st_reg.ctrl[C_FWD];
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			// Without enables in use every channel runs its aligner.
			assign en_eff[g] = st_reg.ctrl[C_ENUSED] ? chan_bit(st_reg.chan, CH_EN, g) : 1'b1;
			assign hold[g] = chan_bit(st_reg.chan, CH_HOLD, g);
			assign drst[g] = chan_bit(st_reg.chan, CH_DRST, g);
			assign lrst[g] = chan_bit(st_reg.chan, CH_LRST, g);
			// The FIFO reset bit has no effect in forwarded mode, where no FIFO is in the path.
			assign frst[g] = (chan_bit(st_reg.chan, CH_FRST, g) && !st_reg.ctrl[C_FWD]) || drst[g]
				|| (st_reg.ctrl[C_AUTO] && !st_reg.first_lock[g]);
			dpa_phase_track u_trk (
				.aclk(aclk),
				.aresetn(aresetn),
				.clr(drst[g]),
				.act(en_eff[g] && !hold[g] && pd_obs[g]),
				.early(pd_early[g]),
				.late(pd_late[g]),
				.phase(phase_sel[g]),
				.step(step[g]),
				.step_up(step_up[g])
			);
			dpa_lock_det u_lock (
				.aclk(aclk),
				.aresetn(aresetn),
				.clr(drst[g] || lrst[g]),
				.obs(pd_obs[g] && en_eff[g]),
				.step(step[g]),
				.step_up(step_up[g]),
				.sticky(st_reg.ctrl[C_STICKY]),
				.cond(st_reg.ctrl[C_COND]),
				.locked(lk_raw[g])
			);
			a_lock_low_rst: assert property (@(posedge aclk) disable iff (!aresetn) (drst[g] || lrst[g]) |=> !dpa_locked[g])
				else $error("Lock high during a reset.");
			a_fifo_held: assert property (@(posedge aclk) disable iff (!aresetn)
				(frst[g] && !st_reg.ctrl[C_FWD]) |=> (st_reg.cnt[g] == '0) && !align_valid[g])
				else $error("FIFO ran while held in reset.");
			a_bypass_data: assert property (@(posedge aclk) disable iff (!aresetn)
				(st_reg.ctrl[C_FWD] && deser_valid[g]) |=> align_valid[g] && align_data[g] == $past(deser_data[g]))
				else $error("Forwarded mode did not bypass the FIFO.");
		end
	endgenerate
	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	// Bus slave, lock gating, FIFO and divider are all computed here from the registered state.
	always_comb begin
		st_next = st_reg;
		wsel = reg_sel(st_reg.awaddr);
		rsel = reg_sel(s_axi_araddr);
		wmerged = '0;
		// Address and data are taken in either order and held until both are present.
		if (s_axi_awvalid && st_reg.awready) begin
			st_next.aw_got = 1'b1;
			st_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_reg.wready) begin
			st_next.w_got = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		// The write lands one cycle after both halves are held; status and phase ignore writes.
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = RESP_OKAY;
			case (wsel)
				RS_CTRL: begin
					wmerged = merge(32'(st_reg.ctrl), st_reg.wdata, st_reg.wstrb);
					st_next.ctrl = wmerged[CTRL_W-1:0];
				end
				RS_CHAN: begin
					wmerged = merge(32'(st_reg.chan), st_reg.wdata, st_reg.wstrb);
					st_next.chan = wmerged[CHAN_W-1:0];
				end
				RS_STAT, RS_PHASE: begin
					st_next.bresp = RESP_OKAY;
				end
				default: begin
					st_next.bresp = RESP_SLVERR;
				end
			endcase
		end
		st_next.awready = !st_next.aw_got && !st_next.bvalid;
		st_next.wready = !st_next.w_got && !st_next.bvalid;
		// A read is answered on the same edge that takes its address.
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_reg.arready) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = RESP_OKAY;
			st_next.rdata = '0;
			case (rsel)
				RS_CTRL: st_next.rdata = 32'(st_reg.ctrl);
				RS_CHAN: st_next.rdata = 32'(st_reg.chan);
				RS_STAT: begin
					st_next.rdata[ST_LOCK +: NCH] = st_reg.lock;
					st_next.rdata[ST_FHELD +: NCH] = st_reg.fheld;
				end
				RS_PHASE: begin
					for (int i = 0; i < NCH; i++) begin
						st_next.rdata[i*PH_STRIDE +: PH_W] = phase_sel[i];
					end
				end
				default: st_next.rresp = RESP_SLVERR;
			endcase
		end
		st_next.arready = !st_next.rvalid;
		// Per channel: lock gating, first-lock memory and the crossing FIFO.
		for (int i = 0; i < NCH; i++) begin
			// Lock is not proof of a clean link; the user still checks data integrity.
			st_next.lock[i] = lock_mode && lk_raw[i] && !drst[i] && !lrst[i];
			if (drst[i]) begin
				st_next.first_lock[i] = 1'b0;
			end else if (lk_raw[i]) begin
				st_next.first_lock[i] = 1'b1;
			end
			st_next.fheld[i] = frst[i];
			st_next.ovalid[i] = 1'b0;
			if (st_reg.ctrl[C_FWD]) begin
				// Forwarded mode hands words straight on and leaves the FIFO empty.
				st_next.odata[i] = deser_data[i];
				st_next.ovalid[i] = deser_valid[i];
				st_next.cnt[i] = '0;
				st_next.wp[i] = '0;
				st_next.rp[i] = '0;
			end else if (frst[i]) begin
				st_next.cnt[i] = '0;
				st_next.wp[i] = '0;
				st_next.rp[i] = '0;
			end else begin
				// The alignment side drains one word a cycle; a word arriving at a full FIFO is lost.
				if (st_reg.cnt[i] != '0) begin
					st_next.odata[i] = st_reg.mem[i][st_reg.rp[i]];
					st_next.ovalid[i] = 1'b1;
					st_next.rp[i] = st_reg.rp[i] + 2'h1;
				end
				if (deser_valid[i] && st_reg.cnt[i] != FIFO_FULL) begin
					st_next.mem[i][st_reg.wp[i]] = deser_data[i];
					st_next.wp[i] = st_reg.wp[i] + 2'h1;
				end
				st_next.cnt[i] = st_reg.cnt[i]
					+ ((deser_valid[i] && st_reg.cnt[i] != FIFO_FULL) ? 3'h1 : 3'h0)
					- ((st_reg.cnt[i] != '0) ? 3'h1 : 3'h0);
			end
		end
		// The forwarded clock is the sampling clock divided by the deserialisation factor.
		if (st_reg.ctrl[C_FWD]) begin
			st_next.div = (st_reg.div == DIV_LAST) ? '0 : st_reg.div + 3'h1;
			st_next.divclk = (st_next.div < DIV_HALF);
		end else begin
			// Parked on the last count so the first forwarded cycle starts a full high half.
			st_next.div = DIV_LAST;
			st_next.divclk = 1'b0;
		end
	end
	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Synchronous reset loads the constant reset image.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end
	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign align_data = st_reg.odata;
	assign align_valid = st_reg.ovalid;
	assign dpa_locked = st_reg.lock;
	assign fwd_div_clk = st_reg.divclk;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_mode_no_lock: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.ctrl[C_FIXED] || st_reg.ctrl[C_FWD]) |=> dpa_locked == '0)
		else $error("Lock reported in a mode without lock.");
	a_disabled_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.ctrl[C_ENUSED] && !st_reg.chan[CH_EN] && !drst[0]) |=> $stable(phase_sel[0]))
		else $error("Disabled channel changed phase.");
	a_fwd_div_period: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.ctrl[C_FWD] && $rose(fwd_div_clk)) |-> ##1 fwd_div_clk [*3] ##1 !fwd_div_clk)
		else $error("Forwarded clock duty wrong.");
endmodule

// ==== dpa_pkg.sv ====
package dpa_pkg;
	// ------------------------------------------------------------
	// Channel structure and phase grid
	// ------------------------------------------------------------
	localparam int NCH = 4; // Receive channels.
	localparam int PH_W = 3; // Width of a phase index.
	localparam int NPHASE = 8; // Sampling clocks per channel.
	localparam int PHASE_DEG = 45; // Spacing of the sampling clocks in degrees.
	localparam logic [PH_W-1:0] PH_ONE = 3'h1; // One phase step.
	localparam int QC_W = 3; // Width of the quiet-observation counter.
	localparam logic [QC_W-1:0] QUIET_LAST = 3'h3; // Quiet observations needed for lock, minus one.
	// ------------------------------------------------------------
	// Data path, FIFO and forwarded clock divider
	// ------------------------------------------------------------
	localparam int DW = 8; // Deserialised word width.
	localparam int FDEPTH = 4; // Words per channel FIFO.
	localparam int FP_W = 2; // FIFO pointer width.
	localparam logic [FP_W:0] FIFO_FULL = 3'h4; // Occupancy of a full FIFO.
	localparam int DIV_W = 3; // Divider counter width.
	localparam logic [DIV_W-1:0] DIV_LAST = 3'h7; // Deserialisation factor minus one.
	localparam logic [DIV_W-1:0] DIV_HALF = 3'h4; // Divided clock is high below this count.
	// ------------------------------------------------------------
	// Register map on the bus
	// ------------------------------------------------------------
	localparam logic [3:0] OFF_CTRL = 4'h0; // Mode register.
	localparam logic [3:0] OFF_CHAN = 4'h4; // Per-channel control register.
	localparam logic [3:0] OFF_STAT = 4'h8; // Per-channel status register.
	localparam logic [3:0] OFF_PHASE = 4'hC; // Selected phase of each channel.
	localparam int CTRL_W = 6; // Implemented bits of the mode register.
	localparam int CHAN_W = 20; // Implemented bits of the channel register.
	localparam int C_FWD = 0; // Forwarded-clock mode, FIFO bypassed.
	localparam int C_FIXED = 1; // Fixed-phase mode.
	localparam int C_STICKY = 2; // Lock stays high once reached.
	localparam int C_COND = 3; // Non-sticky drop: 0 any switch, 1 two same-way switches.
	localparam int C_AUTO = 4; // Hold FIFO in reset until first lock.
	localparam int C_ENUSED = 5; // Per-channel enables are in use.
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h04; // Sticky lock after reset.
	localparam int CH_EN = 0; // Channel enable field base.
	localparam int CH_HOLD = 4; // Phase freeze field base.
	localparam int CH_FRST = 8; // FIFO reset field base.
	localparam int CH_DRST = 12; // Aligner reset field base.
	localparam int CH_LRST = 16; // Lock detector reset field base.
	localparam int ST_LOCK = 0; // Lock field base in the status register.
	localparam int ST_FHELD = 4; // FIFO-held field base in the status register.
	localparam int PH_STRIDE = 4; // Bit spacing of phases in the phase register.
	localparam logic [1:0] RESP_OKAY = 2'h0; // Bus answer for a good access.
	localparam logic [1:0] RESP_SLVERR = 2'h2; // Bus answer for an unmapped address.
	// Register selected by an address.
	typedef enum {RS_CTRL, RS_CHAN, RS_STAT, RS_PHASE, RS_NONE} dpa_reg_t;
	// Lock detector states.
	typedef enum {LK_ACQ, LK_LOCKED} dpa_lk_t;
endpackage

// ==== dpa_phase_track.sv ====
`timescale 1ns/1ps
module dpa_phase_track (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clr,
	input wire logic act,
	input wire logic early,
	input wire logic late,
	output logic [dpa_pkg::PH_W-1:0] phase,
	output logic step,
	output logic step_up
);
	import dpa_pkg::*;
	// Phase index, a one-cycle switch pulse and the direction of that switch.
	typedef struct packed {
		logic [PH_W-1:0] phase;
		logic step;
		logic up;
	} dpa_trk_t;
	dpa_trk_t r_reg, r_next; // Registered state and its next value.
	// ------------------------------------------------------------
	// Phase selection
	// ------------------------------------------------------------
	// Each active observation that is early or late, but not both, moves one 45 degree step; the index wraps around eight.
	always_comb begin
		r_next = r_reg;
		r_next.step = 1'b0;
		if (clr) begin
			r_next = '0;
		end else if (act && (early ^ late)) begin
			r_next.phase = early ? r_reg.phase - PH_ONE : r_reg.phase + PH_ONE;
			r_next.step = 1'b1;
			r_next.up = late;
		end
	end
	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
	assign phase = r_reg.phase;
	assign step = r_reg.step;
	assign step_up = r_reg.up;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_hold_keeps_phase: assert property (@(posedge aclk) disable iff (!aresetn) (!act && !clr) |=> $stable(phase))
		else $error("Phase moved while frozen.");
	a_observe_moves: assert property (@(posedge aclk) disable iff (!aresetn) (act && !clr && (early ^ late)) |=> step)
		else $error("Observation did not switch phase.");
	a_single_step: assert property (@(posedge aclk) disable iff (!aresetn)
		step |-> (phase == $past(phase) + PH_ONE) || (phase == $past(phase) - PH_ONE))
		else $error("Phase moved more than one step.");
endmodule

// ==== dpa_lock_det.sv ====
`timescale 1ns/1ps
module dpa_lock_det (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clr,
	input wire logic obs,
	input wire logic step,
	input wire logic step_up,
	input wire logic sticky,
	input wire logic cond,
	output logic locked
);
	import dpa_pkg::*;
	// Acquire/locked state, quiet count and the direction of the last switch.
	typedef struct packed {
		dpa_lk_t st;
		logic [QC_W-1:0] quiet;
		logic have_last;
		logic last_up;
	} dpa_lkst_t;
	dpa_lkst_t r_reg, r_next; // Registered state and its next value.
	// ------------------------------------------------------------
	// Lock detection
	// ------------------------------------------------------------
	// Lock needs a run of observations with no switch, so one lucky sample cannot claim it.
	always_comb begin
		r_next = r_reg;
		case (r_reg.st)
			LK_ACQ: begin
				if (step) begin
					r_next.quiet = '0;
				end else if (obs) begin
					r_next.quiet = r_reg.quiet + 3'h1;
					if (r_reg.quiet == QUIET_LAST) begin
						r_next.st = LK_LOCKED;
						r_next.have_last = 1'b0;
					end
				end
			end
			LK_LOCKED: begin
				// Sticky lock ignores switches; only a reset ends it.
				if (!sticky && step) begin
					r_next.have_last = 1'b1;
					r_next.last_up = step_up;
					if (!cond || (r_reg.have_last && r_reg.last_up == step_up)) begin
						r_next.st = LK_ACQ;
						r_next.quiet = '0;
					end
				end
			end
			default: begin
				r_next.st = LK_ACQ;
			end
		endcase
		if (clr) begin
			r_next = '{st: LK_ACQ, default: '0};
		end
	end
	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '{st: LK_ACQ, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end
	assign locked = (r_reg.st == LK_LOCKED);
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_lock_after_quiet: assert property (@(posedge aclk) disable iff (!aresetn) $rose(locked) |-> $past(obs && !step))
		else $error("Lock rose without a quiet observation.");
	a_sticky_holds: assert property (@(posedge aclk) disable iff (!aresetn) (locked && sticky && !clr) |=> locked)
		else $error("Sticky lock fell without reset.");
	a_switch_drops: assert property (@(posedge aclk) disable iff (!aresetn)
		(locked && !sticky && !cond && step && !clr) |=> !locked)
		else $error("Lock kept after a phase switch.");
	a_clear_drops: assert property (@(posedge aclk) disable iff (!aresetn) clr |=> !locked)
		else $error("Lock kept through detector reset.");
endmodule

// ==== dpa_tx_model.sv ====
`timescale 1ns/1ps
module dpa_tx_model
	import dpa_pkg::*;
(
	input wire logic aclk,
	input wire logic go,
	input wire logic [1:0] dir,
	output logic [NCH-1:0] pd_obs,
	output logic [NCH-1:0] pd_early,
	output logic [NCH-1:0] pd_late
);
	// ------------------------------------------------------------
	// Phase observations seen by every channel
	// ------------------------------------------------------------
	// Direction lines hold junk between strobes, so a receiver that looks at them off-strobe gets caught.
	initial pd_early = '0;
	initial pd_late = '0;
	always @(posedge aclk) begin
		pd_obs <= {NCH{go}};
		pd_early <= go ? {NCH{dir[1]}} : ~pd_early;
		pd_late <= go ? {NCH{dir[0]}} : ~pd_late;
	end
endmodule

// ==== tb_dpa_align_ctrl.sv ====
`timescale 1ns/1ps
module tb_dpa_align_ctrl;
	import dpa_pkg::*;
	// ------------------------------------------------------------
	// Bench signals
	// ------------------------------------------------------------
	logic aclk = 0, aresetn = 0, go = 0;
	logic [1:0] dir = 0, s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd, n;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fwd_div_clk;
	logic [NCH-1:0] pd_obs, pd_early, pd_late, align_valid, dpa_locked, deser_valid = 0;
	logic [NCH-1:0][DW-1:0] deser_data = 0, align_data;
	logic [NCH-1:0][PH_W-1:0] phase_sel;
	int fails = 0, total_checks = 0;
	always #25 aclk = ~aclk;
	dpa_tx_model dpa_tx_model_inst (.aclk, .go, .dir, .pd_obs, .pd_early, .pd_late);
	dpa_align_ctrl dpa_align_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pd_obs, .pd_early, .pd_late, .deser_data, .deser_valid,
		.align_data, .align_valid, .dpa_locked, .phase_sel, .fwd_div_clk);
	// ------------------------------------------------------------
	// Reporting and bus tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Address and data go out together; each is dropped once taken, and a spent bound ends the run.
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		repeat (40) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 0;
				chk("bresp", s_axi_bresp, er);
				repeat (2) @(posedge aclk);
				return;
			end
		end
		fails++;
		print_verdict();
	endtask
	task automatic rdr(input logic [31:0] a, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		repeat (40) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 0;
				rd = s_axi_rdata;
				chk("rresp", s_axi_rresp, er);
				return;
			end
		end
		fails++;
		print_verdict();
	endtask
	// Sends n observations; the gap lets phase and lock settle before anyone looks.
	task automatic obs(input logic [1:0] d, input int n);
		repeat (n) begin
			go <= 1;
			dir <= d;
			@(posedge aclk);
			go <= 0;
			repeat (5) @(posedge aclk);
		end
	endtask
	// Offers one word on every channel for a cycle, then waits lat edges for it to come out.
	task automatic send(input logic [31:0] w, input int lat);
		deser_data <= w;
		deser_valid <= '1;
		@(posedge aclk);
		deser_valid <= '0;
		repeat (lat) @(posedge aclk);
	endtask
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		rdr(OFF_CTRL, RESP_OKAY);
		chk("ctrl", rd, 32'h4);
		chk("divclk", fwd_div_clk, 32'h0);
		rdr(32'h10, RESP_SLVERR);
		wr(32'h10, 32'hF, RESP_SLVERR);
		$display("test registers done");
		obs(2'h0, 3);
		chk("locked", dpa_locked, 32'h0);
		obs(2'h0, 1);
		chk("locked", dpa_locked, 32'hF);
		rdr(OFF_STAT, RESP_OKAY);
		chk("stat", rd, 32'hF);
		obs(2'h1, 1);
		chk("phase", phase_sel, 32'h249);
		chk("locked", dpa_locked, 32'hF);
		wr(OFF_CHAN, 32'hF0, RESP_OKAY);
		obs(2'h1, 1);
		chk("phase", phase_sel, 32'h249);
		wr(OFF_CHAN, 32'hF0000, RESP_OKAY);
		chk("locked", dpa_locked, 32'h0);
		chk("phase", phase_sel, 32'h249);
		wr(OFF_CHAN, 32'hF000, RESP_OKAY);
		chk("phase", phase_sel, 32'h0);
		wr(OFF_CHAN, 32'h0, RESP_OKAY);
		$display("test sticky done");
		wr(OFF_CTRL, 32'h0, RESP_OKAY);
		obs(2'h0, 4);
		chk("locked", dpa_locked, 32'hF);
		obs(2'h1, 1);
		chk("locked", dpa_locked, 32'h0);
		wr(OFF_CTRL, 32'h8, RESP_OKAY);
		obs(2'h0, 4);
		obs(2'h1, 1);
		chk("locked", dpa_locked, 32'hF);
		obs(2'h1, 1);
		chk("locked", dpa_locked, 32'h0);
		chk("phase", phase_sel, 32'h6DB);
		wr(OFF_CTRL, 32'h20, RESP_OKAY);
		wr(OFF_CHAN, 32'h1, RESP_OKAY);
		obs(2'h2, 1);
		chk("phase", phase_sel, 32'h6DA);
		wr(OFF_CTRL, 32'h6, RESP_OKAY);
		obs(2'h0, 4);
		chk("locked", dpa_locked, 32'h0);
		$display("test modes done");
		wr(OFF_CTRL, 32'h14, RESP_OKAY);
		wr(OFF_CHAN, 32'hF000, RESP_OKAY);
		wr(OFF_CHAN, 32'h0, RESP_OKAY);
		rdr(OFF_STAT, RESP_OKAY);
		chk("stat", rd, 32'hF0);
		send(32'h11223344, 2);
		chk("avalid", align_valid, 32'h0);
		obs(2'h0, 4);
		rdr(OFF_STAT, RESP_OKAY);
		chk("stat", rd, 32'hF);
		send(32'hA55A3CC3, 2);
		chk("avalid", align_valid, 32'hF);
		chk("adata", align_data, 32'hA55A3CC3);
		wr(OFF_CTRL, 32'h1, RESP_OKAY);
		chk("locked", dpa_locked, 32'h0);
		wr(OFF_CHAN, 32'hF00, RESP_OKAY);
		rdr(OFF_STAT, RESP_OKAY);
		chk("stat", rd, 32'h0);
		send(32'h5AC3E10F, 1);
		chk("adata", align_data, 32'h5AC3E10F);
		chk("avalid", align_valid, 32'hF);
		n = 0;
		repeat (8) begin
			@(posedge aclk);
			n = n + fwd_div_clk;
		end
		chk("divhigh", n, 32'h4);
		$display("test fifo done");
		print_verdict();
	end
endmodule
